//--- hsnu_regs.sv
// Host speed host_speed_flag_a and memory unlock registers behind a serial slave
// How it works
// - Address 0x08 reads die identifier high byte, revision code low byte.
// - Revision code is a fixed 8-bit count, same on every read.
// - Addresses 0x09 to 0x2F hold nothing; read zero, writes dropped.
// - Speed control bit 15 is a writable host_speed_flag_a flag, reset zero.
// - Host_speed_flag_a set selects host 9-bit speed value over other inputs.
// - Speed control bits 14 to 9 read zero; host must not write.
// - Address 0x31 is a 16-bit read/write unlock key, reset zero.
// - Customer memory opens only while the key holds 0xC0DE.
// - Address 0x32 bit 0 reads memory ready, one when accessible.
// - Status bits 15 to 1 read zero; host must not access.
// - Speed, key and status registers come out of reset all zero.
`timescale 1ns/100ps
`default_nettype none
`include "hsnu_map.svh"

module hsnu_regs
    import hsnu_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_arst_n,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe,
    input  wire logic [8:0] i_speed_other,
    input  wire logic       i_nvm_busy,
    output logic [8:0]      o_speed_cmd,
    output logic            o_speed_host_speed_flag_a,
    output logic            o_nvm_unlocked
);

    // ========================================
    // Pin filtering and edge detection
    hsnu_bus_pins_t pins_raw;
    hsnu_bus_pins_t pins;
    hsnu_bus_pins_t pins_q;

    assign pins_raw.scl = i_scl;
    assign pins_raw.sda = i_sda;

    hsnu_pin_sync u_sync (
        .i_mclk   (i_mclk),
        .i_arst_n (i_arst_n),
        .i_pins   (pins_raw),
        .o_pins   (pins)
    );

    // Previous filtered levels
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pins_q <= 2'b11;
        end else begin
            pins_q <= pins;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    // Start and stop are SDA moves while SCL stays high
    assign scl_rise  = pins.scl & ~pins_q.scl;
    assign scl_fall  = ~pins.scl & pins_q.scl;
    assign bus_start = pins.scl & pins_q.scl & ~pins.sda & pins_q.sda;
    assign bus_stop  = pins.scl & pins_q.scl & pins.sda & ~pins_q.sda;

    // ========================================
    // Register storage
    hsnu_speed_ctl_t speed_ctl;
    hsnu_speed_ctl_t next_speed_ctl;
    logic [15:0]     unlock_key;
    logic [15:0]     next_unlock_key;
    logic            nvm_ready;
    logic            wr_en;
    logic [7:0]      wr_addr;
    logic [15:0]     wr_data;

    // Host writes land only in writable fields
    always_comb begin
        next_speed_ctl  = speed_ctl;
        next_unlock_key = unlock_key;
        if (wr_en) begin
            case (wr_addr)
                `HSNU_ADDR_SPEED_CTL: begin
                    next_speed_ctl.flag  = wr_data[`HSNU_SPEED_FLAG_BIT];
                    next_speed_ctl.value =
                        wr_data[`HSNU_SPEED_VAL_MSB:`HSNU_SPEED_VAL_LSB];
                end
                `HSNU_ADDR_UNLOCK_KEY: begin
                    next_unlock_key = wr_data;
                end
                // Identity, status, gap and unmapped writes are dropped
                default: next_speed_ctl = speed_ctl;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            speed_ctl.flag  <= `HSNU_RST_SPEED_FLAG;
            speed_ctl.value <= `HSNU_RST_SPEED_VAL;
            unlock_key      <= `HSNU_RST_UNLOCK_KEY;
            nvm_ready       <= `HSNU_RST_READY;
        end else begin
            speed_ctl  <= next_speed_ctl;
            unlock_key <= next_unlock_key;
            nvm_ready  <= ~i_nvm_busy;
        end
    end

    // ========================================
    // Read multiplexer
    logic [7:0]  reg_ptr;
    logic [15:0] rd_data;

    // Reserved bits and the unused gap read as zero
    always_comb begin
        rd_data = 16'h0000;
        case (reg_ptr)
            `HSNU_ADDR_IDENT: begin
                rd_data = {`HSNU_DIE_IDENT, `HSNU_REV_CODE};
            end
            `HSNU_ADDR_SPEED_CTL: begin
                rd_data = {speed_ctl.flag, 6'h00, speed_ctl.value};
            end
            `HSNU_ADDR_UNLOCK_KEY: rd_data = unlock_key;
            `HSNU_ADDR_READY_STAT: rd_data = {15'h0000, nvm_ready};
            default:               rd_data = 16'h0000;
        endcase
    end

    // ========================================
    // Serial slave
    // Frame: address, register pointer, data high, data low
    hsnu_state_t state;
    hsnu_state_t next_state;
    logic [7:0]  shift;
    logic [7:0]  next_shift;
    logic [3:0]  bit_cnt;
    logic [3:0]  next_bit_cnt;
    logic [1:0]  byte_idx;
    logic [1:0]  next_byte_idx;
    logic        rw;
    logic        next_rw;
    logic [7:0]  next_reg_ptr;
    logic [7:0]  data_hi;
    logic [7:0]  next_data_hi;
    logic [15:0] rd_word;
    logic [15:0] next_rd_word;
    logic        rd_lo;
    logic        next_rd_lo;
    logic        nack;
    logic        next_nack;
    logic        sda_oe;
    logic        next_sda_oe;
    logic [7:0]  rd_byte;

    assign rd_byte = rd_lo ? rd_word[7:0] : rd_word[15:8];

    always_comb begin
        next_state    = state;
        next_shift    = shift;
        next_bit_cnt  = bit_cnt;
        next_byte_idx = byte_idx;
        next_rw       = rw;
        next_reg_ptr  = reg_ptr;
        next_data_hi  = data_hi;
        next_rd_word  = rd_word;
        next_rd_lo    = rd_lo;
        next_nack     = nack;
        next_sda_oe   = sda_oe;
        wr_en         = 1'b0;
        wr_addr       = reg_ptr;
        wr_data       = {data_hi, shift};
        if (bus_stop) begin
            next_state  = ST_IDLE;
            next_sda_oe = 1'b0;
        end else if (bus_start) begin
            // Repeated start keeps the register pointer
            next_state    = ST_ADDR;
            next_bit_cnt  = 4'h0;
            next_byte_idx = 2'h0;
            next_sda_oe   = 1'b0;
        end else begin
            case (state)
                ST_IDLE: next_sda_oe = 1'b0;
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise && bit_cnt != `HSNU_BITS_PER_BYTE) begin
                        next_shift   = {shift[6:0], pins.sda};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (scl_fall &&
                                 bit_cnt == `HSNU_BITS_PER_BYTE) begin
                        next_bit_cnt = 4'h0;
                        if (state == ST_ADDR) begin
                            if (shift[7:1] == `HSNU_DEV_ADDR) begin
                                next_rw     = shift[0];
                                next_sda_oe = 1'b1;
                                next_state  = ST_ACK;
                            end else begin
                                next_state = ST_IDLE;
                            end
                        end else begin
                            next_sda_oe = 1'b1;
                            next_state  = ST_ACK;
                            case (byte_idx)
                                2'h0: begin
                                    next_reg_ptr  = shift;
                                    next_byte_idx = 2'h1;
                                end
                                2'h1: begin
                                    next_data_hi  = shift;
                                    next_byte_idx = 2'h2;
                                end
                                default: begin
                                    // Whole word commits; pointer advances
                                    wr_en         = 1'b1;
                                    next_reg_ptr  = reg_ptr + 8'h01;
                                    next_byte_idx = 2'h1;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        if (rw) begin
                            // Snapshot word so both bytes match
                            next_rd_word = rd_data;
                            next_rd_lo   = 1'b0;
                            next_sda_oe  = ~rd_data[15];
                            next_bit_cnt = 4'h1;
                            next_state   = ST_READ;
                        end else begin
                            next_sda_oe = 1'b0;
                            next_state  = ST_WRITE;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        if (bit_cnt == `HSNU_BITS_PER_BYTE) begin
                            next_sda_oe = 1'b0;
                            next_state  = ST_RACK;
                        end else begin
                            next_sda_oe  = ~rd_byte[3'h7 - bit_cnt[2:0]];
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        next_nack = pins.sda;
                    end else if (scl_fall) begin
                        if (nack) begin
                            next_state = ST_IDLE;
                        end else if (!rd_lo) begin
                            next_rd_lo   = 1'b1;
                            next_sda_oe  = ~rd_word[7];
                            next_bit_cnt = 4'h1;
                            next_state   = ST_READ;
                        end else begin
                            // Sequential read moves to the next word
                            next_reg_ptr = reg_ptr + 8'h01;
                            next_state   = ST_ACK;
                            next_sda_oe  = 1'b0;
                            next_rw      = 1'b1;
                        end
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state    <= ST_IDLE;
            shift    <= 8'h00;
            bit_cnt  <= 4'h0;
            byte_idx <= 2'h0;
            rw       <= 1'b0;
            reg_ptr  <= 8'h00;
            data_hi  <= 8'h00;
            rd_word  <= 16'h0000;
            rd_lo    <= 1'b0;
            nack     <= 1'b0;
            sda_oe   <= 1'b0;
        end else begin
            state    <= next_state;
            shift    <= next_shift;
            bit_cnt  <= next_bit_cnt;
            byte_idx <= next_byte_idx;
            rw       <= next_rw;
            reg_ptr  <= next_reg_ptr;
            data_hi  <= next_data_hi;
            rd_word  <= next_rd_word;
            rd_lo    <= next_rd_lo;
            nack     <= next_nack;
            sda_oe   <= next_sda_oe;
        end
    end

    // ========================================
    // Outputs, all registered
    logic [8:0] next_speed_cmd;
    logic       next_unlocked;

    always_comb begin
        next_speed_cmd = speed_ctl.flag ? speed_ctl.value
                                        : i_speed_other;
        next_unlocked  = (unlock_key == `HSNU_UNLOCK_CODE);
    end

    // Open-drain: data pin is only ever pulled low
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sda            <= 1'b0;
            o_sda_oe         <= 1'b0;
            o_speed_cmd      <= 9'h000;
            o_speed_host_speed_flag_a <= 1'b0;
            o_nvm_unlocked   <= 1'b0;
        end else begin
            o_sda            <= 1'b0;
            o_sda_oe         <= sda_oe;
            o_speed_cmd      <= next_speed_cmd;
            o_speed_host_speed_flag_a <= speed_ctl.flag;
            o_nvm_unlocked   <= next_unlocked;
        end
    end

endmodule

`default_nettype wire

//--- hsnu_map.svh
// Register offsets, field positions, reset values and constants
`ifndef HSNU_MAP_SVH
`define HSNU_MAP_SVH

// ========================================
// Register offsets
`define HSNU_ADDR_IDENT        8'h08
`define HSNU_ADDR_GAP_LO       8'h09
`define HSNU_ADDR_GAP_HI       8'h2f
`define HSNU_ADDR_SPEED_CTL    8'h30
`define HSNU_ADDR_UNLOCK_KEY   8'h31
`define HSNU_ADDR_READY_STAT   8'h32

// ========================================
// Field positions
`define HSNU_IDENT_DIE_MSB     15
`define HSNU_IDENT_DIE_LSB     8
`define HSNU_IDENT_REV_MSB     7
`define HSNU_IDENT_REV_LSB     0
`define HSNU_SPEED_FLAG_BIT    15
`define HSNU_SPEED_RSVD_MSB    14
`define HSNU_SPEED_RSVD_LSB    9
`define HSNU_SPEED_VAL_MSB     8
`define HSNU_SPEED_VAL_LSB     0
`define HSNU_READY_BIT         0

// ========================================
// Reset values and fixed codes
`define HSNU_RST_SPEED_FLAG    1'b0
`define HSNU_RST_SPEED_VAL     9'h000
`define HSNU_RST_UNLOCK_KEY    16'h0000
`define HSNU_RST_READY         1'b0
`define HSNU_UNLOCK_CODE       16'hc0de
// Arbitrary identity values, not tied to any real part
`define HSNU_DIE_IDENT         8'h5a
`define HSNU_REV_CODE          8'h03
// Arbitrary 7-bit serial address of this device
`define HSNU_DEV_ADDR          7'h52
`define HSNU_BITS_PER_BYTE     4'h8

`endif

//--- hsnu_pkg.sv
// Types shared by the register bank files
package hsnu_pkg;

    // Host speed control contents
    typedef struct packed {
        logic       flag;
        logic [8:0] value;
    } hsnu_speed_ctl_t;

    // Serial bus pins after filtering
    typedef struct packed {
        logic scl;
        logic sda;
    } hsnu_bus_pins_t;

    // Serial slave states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_WRITE,
        ST_READ,
        ST_RACK
    } hsnu_state_t;

endpackage

//--- hsnu_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none

module hsnu_pin_sync
    import hsnu_pkg::*;
(
    input  wire logic           i_mclk,
    input  wire logic           i_arst_n,
    input  wire hsnu_bus_pins_t i_pins,
    output var  hsnu_bus_pins_t o_pins
);

    // ========================================
    // Per-bit synchroniser
    // Idle bus level is high, so all stages reset to one
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] filt;
    logic [1:0] next_filt;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_bit
            // Change taken only when stages two and three agree
            always_comb begin
                next_filt[g] = (s2[g] == s3[g]) ? s3[g] : filt[g];
            end

            always_ff @(posedge i_mclk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    s1[g]   <= 1'b1;
                    s2[g]   <= 1'b1;
                    s3[g]   <= 1'b1;
                    filt[g] <= 1'b1;
                end else begin
                    s1[g]   <= i_pins[g];
                    s2[g]   <= s1[g];
                    s3[g]   <= s2[g];
                    filt[g] <= next_filt[g];
                end
            end
        end
    endgenerate

    assign o_pins = filt;

endmodule

`default_nettype wire

//--- hsnu_regs_assertions.sv
// Pin-level timing checks for the speed and unlock register bank
`timescale 1ns/100ps
`default_nettype none

module hsnu_regs_chk (
    input wire logic       i_mclk,
    input wire logic       i_arst_n,
    input wire logic       i_scl,
    input wire logic       i_sda,
    input wire logic       o_sda,
    input wire logic       o_sda_oe,
    input wire logic [8:0] i_speed_other,
    input wire logic       i_nvm_busy,
    input wire logic [8:0] o_speed_cmd,
    input wire logic       o_speed_host_speed_flag_a,
    input wire logic       o_nvm_unlocked
);
    // ========================================
    // Assertions
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);

    // Everything comes out of reset cleared
    chk_reset_clear: assert property (
        $rose(i_arst_n) |-> !o_speed_host_speed_flag_a && !o_nvm_unlocked
            && o_speed_cmd == 9'h000)
        else $error("outputs not clear after reset");
    // Without host_speed_flag_a the command follows the other source, one late
    chk_other_path: assert property (
        !o_speed_host_speed_flag_a [*4] |-> o_speed_cmd == $past(i_speed_other, 1))
        else $error("speed command not from other source");
    // With host_speed_flag_a the other source must not leak through
    chk_host_path: assert property (
        o_speed_host_speed_flag_a && $past(o_speed_host_speed_flag_a) && i_scl
            |-> $stable(o_speed_cmd))
        else $error("speed command moved under host_speed_flag_a");
    // Flags only move on a write commit, which lands while the clock is low
    chk_flag_when_low: assert property (
        $changed(o_speed_host_speed_flag_a) |-> !i_scl)
        else $error("host_speed_flag_a flag moved outside a write");
    chk_key_when_low: assert property (
        $changed(o_nvm_unlocked) |-> !i_scl)
        else $error("unlock state moved outside a write");
    // Open drain: the pin is only ever pulled low
    chk_drive_low_only: assert property (
        o_sda_oe |-> !o_sda)
        else $error("data pin driven high");
    // Data pin drive changes only well into a low clock phase
    chk_ack_edge: assert property (
        $changed(o_sda_oe) |-> !i_scl && !$past(i_scl, 3))
        else $error("data drive changed near a clock high");
    // Start and stop edges belong to the host alone
    chk_start_free: assert property (
        i_scl && $past(i_scl) && $changed(i_sda) |-> !o_sda_oe)
        else $error("device drove the pin during start or stop");

    // ========================================
    // Coverage
    cov_host_speed_flag_a: cover property ($rose(o_speed_host_speed_flag_a));
    cov_unlock: cover property ($rose(o_nvm_unlocked));
    cov_ack: cover property ($rose(o_sda_oe));
endmodule

bind hsnu_regs hsnu_regs_chk u_hsnu_regs_chk (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_speed_other(i_speed_other),
    .i_nvm_busy(i_nvm_busy), .o_speed_cmd(o_speed_cmd),
    .o_speed_host_speed_flag_a(o_speed_host_speed_flag_a), .o_nvm_unlocked(o_nvm_unlocked)
);

`default_nettype wire

//--- hsnu_host_model.sv
// Behavioural two-wire host that reaches the register bank
`timescale 1ns/100ps
`default_nettype none
`include "hsnu_map.svh"

module hsnu_host_model (
    input  wire logic i_mclk,
    input  wire logic i_sda,
    output var  logic o_scl,
    output var  logic o_sda
);
    // ========================================
    // Bus timing
    // Half period kept well above the four clocks the pin filter needs
    localparam int HALF = 10;

    // Both lines released at power up
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    // ========================================
    // Bus conditions
    // Waits a half period first so a device ack has been released
    task automatic start();
        o_sda = 1'b1;
        wt(HALF);
        o_scl = 1'b1;
        wt(HALF);
        o_sda = 1'b0;
        wt(HALF);
        o_scl = 1'b0;
        wt(2);
    endtask

    task automatic stop();
        o_sda = 1'b0;
        wt(HALF);
        o_scl = 1'b1;
        wt(HALF);
        o_sda = 1'b1;
        wt(HALF);
    endtask

    // Data moves two clocks after the clock falls, never beside it
    task automatic sendbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda = b[i];
            wt(HALF - 2);
            o_scl = 1'b1;
            wt(HALF);
            o_scl = 1'b0;
            wt(2);
        end
        o_sda = 1'b1;
        wt(HALF - 2);
        o_scl = 1'b1;
        wt(HALF / 2);
        ack = ~i_sda;
        wt(HALF / 2);
        o_scl = 1'b0;
        wt(2);
    endtask

    task automatic recvbyte(input logic nack, output logic [7:0] b);
        o_sda = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            wt(HALF - 2);
            o_scl = 1'b1;
            wt(HALF / 2);
            b[i] = i_sda;
            wt(HALF / 2);
            o_scl = 1'b0;
            wt(2);
        end
        o_sda = nack;
        wt(HALF - 2);
        o_scl = 1'b1;
        wt(HALF);
        o_scl = 1'b0;
        wt(2);
    endtask

    // ========================================
    // Register transfers, high byte first
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      output logic ok);
        logic [3:0] k;
        start();
        sendbyte({`HSNU_DEV_ADDR, 1'b0}, k[3]);
        sendbyte(a, k[2]);
        sendbyte(d[15:8], k[1]);
        sendbyte(d[7:0], k[0]);
        stop();
        ok = &k;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic ok);
        logic [2:0] k;
        start();
        sendbyte({`HSNU_DEV_ADDR, 1'b0}, k[2]);
        sendbyte(a, k[1]);
        start();
        sendbyte({`HSNU_DEV_ADDR, 1'b1}, k[0]);
        recvbyte(1'b0, d[15:8]);
        recvbyte(1'b1, d[7:0]);
        stop();
        ok = &k;
    endtask

    // Polls ready up to eight times, then writes the key even if ready never showed
    task automatic unlock(output logic ok);
        logic [15:0] st;
        logic        rok;
        st = 16'h0000;
        for (int n = 0; n < 8 && st[0] !== 1'b1; n++) begin
            rd(`HSNU_ADDR_READY_STAT, st, rok);
        end
        wr(`HSNU_ADDR_UNLOCK_KEY, `HSNU_UNLOCK_CODE, ok);
        ok = ok & st[0];
    endtask
endmodule

`default_nettype wire

//--- testbench.sv
// Self-checking bench for the speed host_speed_flag_a and unlock registers
`timescale 1ns/100ps
`default_nettype none
`include "hsnu_map.svh"

module testbench;
    localparam int LIMIT = 60000;
    logic       mclk = 1'b0;
    logic       arst_n = 1'b0;
    logic       scl;
    logic       sda_host;
    logic       sda_line;
    logic       sda_drv;
    logic       sda_oe;
    logic [8:0] other = 9'h000;
    logic       busy = 1'b1;
    logic [8:0] cmd;
    logic       ovr;
    logic       unl;
    int         bad_count = 0;
    int         compares = 0;
    int         cycles = 0;

    // ========================================
    // Clock, pin and instances
    always #10 mclk = ~mclk;
    // Pull-up wins unless someone pulls the line low
    assign sda_line = sda_host & ~(sda_oe & ~sda_drv);

    hsnu_regs u_hsnu_regs (
        .i_mclk          (mclk),
        .i_arst_n        (arst_n),
        .i_scl           (scl),
        .i_sda           (sda_line),
        .o_sda           (sda_drv),
        .o_sda_oe        (sda_oe),
        .i_speed_other   (other),
        .i_nvm_busy      (busy),
        .o_speed_cmd     (cmd),
        .o_speed_host_speed_flag_a(ovr),
        .o_nvm_unlocked  (unl)
    );
    hsnu_host_model u_hsnu_host_model (
        .i_mclk(mclk),
        .i_sda (sda_line),
        .o_scl (scl),
        .o_sda (sda_host)
    );

    // ========================================
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [15:0] d);
        logic ok;
        u_hsnu_host_model.wr(a, d, ok);
        chk({15'h0000, ok}, 16'h0001);
    endtask

    task automatic r(input logic [7:0] a, input logic [15:0] exp);
        logic        ok;
        logic [15:0] d;
        u_hsnu_host_model.rd(a, d, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(d, exp);
    endtask

    // Reset lands on a falling edge, then the pin filter settles
    task automatic do_reset();
        arst_n = 1'b0;
        repeat (4) @(negedge mclk);
        arst_n = 1'b1;
        repeat (6) @(negedge mclk);
    endtask

    // ========================================
    // Scenarios
    task automatic t_reset_state();
        chk({15'h0000, ovr}, 16'h0000);
        chk({15'h0000, unl}, 16'h0000);
        chk({7'h00, cmd}, {7'h00, other});
        r(`HSNU_ADDR_SPEED_CTL, 16'h0000);
        r(`HSNU_ADDR_UNLOCK_KEY, 16'h0000);
        r(`HSNU_ADDR_READY_STAT, 16'h0000);
    endtask

    task automatic t_ident();
        r(`HSNU_ADDR_IDENT, {`HSNU_DIE_IDENT, `HSNU_REV_CODE});
        w(`HSNU_ADDR_IDENT, 16'hffff);
        r(`HSNU_ADDR_IDENT, {`HSNU_DIE_IDENT, `HSNU_REV_CODE});
    endtask

    // Both ends of the empty range plus one inside it
    task automatic t_gap();
        logic [7:0] gap [3] = '{8'h09, 8'h1c, 8'h2f};
        foreach (gap[i]) begin
            w(gap[i], 16'hffff);
            r(gap[i], 16'h0000);
        end
    endtask

    task automatic t_speed();
        other = 9'h0aa;
        w(`HSNU_ADDR_SPEED_CTL, 16'hfe55);
        r(`HSNU_ADDR_SPEED_CTL, 16'h8055);
        chk({15'h0000, ovr}, 16'h0001);
        chk({7'h00, cmd}, 16'h0055);
        other = 9'h1f0;
        repeat (4) @(negedge mclk);
        chk({7'h00, cmd}, 16'h0055);
        w(`HSNU_ADDR_SPEED_CTL, 16'h7fff);
        r(`HSNU_ADDR_SPEED_CTL, 16'h01ff);
        chk({15'h0000, ovr}, 16'h0000);
        chk({7'h00, cmd}, 16'h01f0);
    endtask

    // A key one bit off must not open the memory
    task automatic t_key();
        logic ok;
        busy = 1'b0;
        w(`HSNU_ADDR_UNLOCK_KEY, 16'hc0df);
        chk({15'h0000, unl}, 16'h0000);
        r(`HSNU_ADDR_UNLOCK_KEY, 16'hc0df);
        u_hsnu_host_model.unlock(ok);
        chk({15'h0000, ok}, 16'h0001);
        chk({15'h0000, unl}, 16'h0001);
        r(`HSNU_ADDR_UNLOCK_KEY, `HSNU_UNLOCK_CODE);
        w(`HSNU_ADDR_UNLOCK_KEY, 16'h40de);
        chk({15'h0000, unl}, 16'h0000);
    endtask

    task automatic t_ready();
        busy = 1'b1;
        r(`HSNU_ADDR_READY_STAT, 16'h0000);
        busy = 1'b0;
        r(`HSNU_ADDR_READY_STAT, 16'h0001);
        w(`HSNU_ADDR_READY_STAT, 16'hfffe);
        r(`HSNU_ADDR_READY_STAT, 16'h0001);
    endtask

    // Another device address must go unanswered
    task automatic t_wrong_addr();
        logic ack;
        u_hsnu_host_model.start();
        u_hsnu_host_model.sendbyte({`HSNU_DEV_ADDR ^ 7'h01, 1'b0}, ack);
        u_hsnu_host_model.stop();
        chk({15'h0000, ack}, 16'h0000);
    endtask

    // Reset in mid-run with host_speed_flag_a and key both set
    task automatic t_mid_reset();
        w(`HSNU_ADDR_SPEED_CTL, 16'h8123);
        chk({7'h00, cmd}, 16'h0123);
        w(`HSNU_ADDR_UNLOCK_KEY, `HSNU_UNLOCK_CODE);
        chk({15'h0000, unl}, 16'h0001);
        busy = 1'b1;
        do_reset();
        t_reset_state();
    endtask

    // ========================================
    // Verdict and run control
    task automatic results();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Hang guard, far above the length of the sequence
    always @(posedge mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            results();
        end
    end

    initial begin
        do_reset();
        t_reset_state();
        t_ident();
        t_gap();
        t_speed();
        t_key();
        t_ready();
        t_wrong_addr();
        t_mid_reset();
        results();
    end
endmodule

`default_nettype wire
